// ### core/pbl_pkg.sv
// package: register layout, codes and carriers for the self-test and loopback control
package pbl_pkg;
  localparam logic [4:0] REG_CTRL = 5'h16;
  localparam logic [4:0] REG_IRQ_STATUS = 5'h18;
  localparam logic [4:0] REG_IRQ_ENABLE = 5'h19;
  localparam logic [4:0] REG_IRQ_CLEAR = 5'h1a;
  localparam logic [4:0] REG_ERR_COUNT = 5'h1b;
  localparam logic [4:0] REG_POLY = 5'h1c;
  localparam int BIT_CNT_MODE = 14;
  localparam int BIT_PKT_TYPE = 13;
  localparam int BIT_GEN_EN = 12;
  localparam int BIT_LOCK = 11;
  localparam int BIT_SYNC_LOSS = 10;
  localparam int BIT_GEN_STAT = 9;
  localparam int BIT_MDI_TX = 6;
  localparam int LB_LSB = 2;
  localparam logic [1:0] RSVD_8_7 = 2'h2;
  localparam logic [3:0] LB_NORMAL = 4'h0;
  localparam logic [3:0] LB_PCS = 4'h1;
  localparam logic [3:0] LB_ANALOG = 4'h2;
  localparam logic [3:0] LB_REVERSE = 4'h4;
  localparam logic [3:0] LB_XMII = 4'h8;
  localparam logic [15:0] POLY_RESET = 16'hb400;
  localparam logic [15:0] ERR_MAX = 16'hffff;
  localparam logic [15:0] PKT_LEN = 16'h05ee;
  localparam logic [15:0] IPG_LEN = 16'h000c;
  localparam logic [7:0] CONST_BYTE = 8'h55;
  localparam logic [3:0] LOCK_RUN = 4'h8;
  localparam logic [3:0] LOSS_RUN = 4'h4;
  localparam logic [4:0] SEED_LEN = 5'h10;
  localparam int IRQ_SYNC_LOSS = 0;
  localparam int IRQ_WRAP = 1;
  localparam int IRQ_GEN_DONE = 2;
  typedef enum logic [2:0] {
    GEN_IDLE = 3'h1,
    GEN_DATA = 3'h2,
    GEN_GAP = 3'h4
  } pbl_gen_e;
  typedef struct packed {
    logic [4:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } pbl_bus_s;
  typedef struct packed {
    logic pcs;
    logic analog;
    logic reverse;
    logic xmii;
    logic mdi_tx_en;
  } pbl_path_s;
endpackage

// ### core/pbl_lfsr.sv
// fibonacci shift register shared in form by the generator and checker
`timescale 1ns/100ps
module pbl_lfsr
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic step_i,
  input wire logic load_i,
  input wire logic load_bit_i,
  input wire logic [15:0] poly_i,
  output logic bit_o
);
  typedef struct packed {
    logic [15:0] sr;
  } pbl_lfsr_s;
  pbl_lfsr_s st;
  pbl_lfsr_s next_st;
  always_comb
  begin
    next_st = st;
    if (step_i)
    begin
      // checker seeds by shifting received bits in, so it self-aligns
      next_st.sr = {st.sr[14:0], (load_i ? load_bit_i : ^(st.sr & poly_i))};
      if (next_st.sr == 16'h0000)
      begin
        next_st.sr = 16'h0001;
      end
    end
  end
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      st <= '{sr: 16'h0001};
    end
    else
    begin
      st <= next_st;
    end
  end
  assign bit_o = ^(st.sr & poly_i);
endmodule

// ### core/pbl_bist.sv
// self-test generator, checker, loopback select and register port
`timescale 1ns/100ps
module pbl_bist
(
  input wire logic CLK_I,
  input wire logic RESET_I,
  input wire logic [4:0] ADDR_I,
  input wire logic [15:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  input wire logic RX_VALID_I,
  input wire logic RX_BIT_I,
  output logic [15:0] RDATA_O,
  output logic TX_VALID_O,
  output logic TX_BIT_O,
  output logic TX_SOP_O,
  output logic LB_PCS_O,
  output logic LB_ANALOG_O,
  output logic LB_REVERSE_O,
  output logic LB_XMII_O,
  output logic MDI_TX_EN_O,
  output logic ERR_WRAP_O,
  output logic IRQ_O
);
  typedef struct packed {
    logic cnt_mode;
    logic pkt_type;
    logic gen_en;
    logic [4:0] lb;
    logic [1:0] rsvd_lo;
    logic locked;
    logic sync_loss;
    logic [3:0] run;
    logic [4:0] fill;
    logic [15:0] err_cnt;
    logic [15:0] poly;
    pbl_pkg::pbl_gen_e gen;
    logic [15:0] gen_cnt;
    logic single_done;
    logic [2:0] irq_stat;
    logic [2:0] irq_en;
    logic [15:0] rdata;
    logic tx_valid;
    logic tx_bit;
    logic tx_sop;
    pbl_pkg::pbl_path_s path;
    logic wrap;
    logic irq;
  } pbl_state_s;
  pbl_state_s st;
  pbl_state_s next_st;
  pbl_pkg::pbl_bus_s bus;
  logic gen_prbs_bit;
  logic chk_pred_bit;
  logic gen_step;
  logic chk_on;
  logic chk_step;
  logic mismatch;
  assign bus = '{addr: ADDR_I, wdata: WDATA_I, wr: WR_I, rd: RD_I};
  // generator advances only while sending random payload
  assign gen_step = (next_st.gen == pbl_pkg::GEN_DATA) && st.pkt_type;
  // checker only runs in random mode, whatever the generator does
  assign chk_on = st.pkt_type;
  assign chk_step = chk_on && RX_VALID_I;
  assign mismatch = RX_BIT_I != chk_pred_bit;
  pbl_lfsr u_gen
  (
    .clk_i(CLK_I),
    .reset_i(RESET_I),
    .step_i(gen_step),
    .load_i(1'b0),
    .load_bit_i(1'b0),
    .poly_i(st.poly),
    .bit_o(gen_prbs_bit)
  );
  pbl_lfsr u_chk
  (
    .clk_i(CLK_I),
    .reset_i(RESET_I),
    .step_i(chk_step),
    .load_i(!st.locked),
    .load_bit_i(RX_BIT_I),
    .poly_i(st.poly),
    .bit_o(chk_pred_bit)
  );
  always_comb
  begin
    logic [2:0] ev;
    logic [15:0] ctrl;
    ev = 3'h0;
    next_st = st;
    next_st.wrap = 1'b0;
    next_st.tx_sop = 1'b0;
    ctrl = {1'b0, st.cnt_mode, st.pkt_type, st.gen_en, st.locked, st.sync_loss,
      (st.gen != pbl_pkg::GEN_IDLE), pbl_pkg::RSVD_8_7, st.lb, st.rsvd_lo};
    if (bus.wr && bus.addr == pbl_pkg::REG_CTRL)
    begin
      next_st.cnt_mode = bus.wdata[pbl_pkg::BIT_CNT_MODE];
      next_st.pkt_type = bus.wdata[pbl_pkg::BIT_PKT_TYPE];
      next_st.gen_en = bus.wdata[pbl_pkg::BIT_GEN_EN];
      next_st.lb = bus.wdata[6:2];
      next_st.rsvd_lo = bus.wdata[1:0];
      next_st.single_done = 1'b0;
    end
    if (bus.wr && bus.addr == pbl_pkg::REG_IRQ_ENABLE)
    begin
      next_st.irq_en = bus.wdata[2:0];
    end
    if (bus.wr && bus.addr == pbl_pkg::REG_POLY)
    begin
      next_st.poly = bus.wdata;
    end
    if (bus.wr && bus.addr == pbl_pkg::REG_IRQ_CLEAR)
    begin
      next_st.irq_stat = st.irq_stat & ~bus.wdata[2:0];
    end
    // read-clear of sync loss; a new loss below wins over it
    if (bus.rd && bus.addr == pbl_pkg::REG_CTRL)
    begin
      next_st.sync_loss = 1'b0;
    end
    if (bus.rd)
    begin
      case (bus.addr)
        pbl_pkg::REG_CTRL: next_st.rdata = ctrl;
        pbl_pkg::REG_IRQ_STATUS: next_st.rdata = {13'h0000, st.irq_stat};
        pbl_pkg::REG_IRQ_ENABLE: next_st.rdata = {13'h0000, st.irq_en};
        pbl_pkg::REG_ERR_COUNT: next_st.rdata = st.err_cnt;
        pbl_pkg::REG_POLY: next_st.rdata = st.poly;
        default: next_st.rdata = 16'h0000;
      endcase
    end
    else
    begin
      next_st.rdata = 16'h0000;
    end
    // generator
    case (st.gen)
      pbl_pkg::GEN_IDLE:
      begin
        next_st.tx_valid = 1'b0;
        if (st.gen_en && !st.single_done)
        begin
          next_st.gen = pbl_pkg::GEN_DATA;
          next_st.gen_cnt = 16'h0000;
          next_st.tx_sop = 1'b1;
        end
      end
      pbl_pkg::GEN_DATA:
      begin
        next_st.tx_valid = 1'b1;
        next_st.gen_cnt = st.gen_cnt + 16'h0001;
        if (!st.gen_en)
        begin
          next_st.gen = pbl_pkg::GEN_IDLE;
          next_st.tx_valid = 1'b0;
        end
        else if (st.gen_cnt == pbl_pkg::PKT_LEN - 16'h0001)
        begin
          next_st.gen = pbl_pkg::GEN_GAP;
          next_st.gen_cnt = 16'h0000;
        end
      end
      pbl_pkg::GEN_GAP:
      begin
        next_st.tx_valid = 1'b0;
        next_st.gen_cnt = st.gen_cnt + 16'h0001;
        if (!st.gen_en)
        begin
          next_st.gen = pbl_pkg::GEN_IDLE;
        end
        else if (!st.pkt_type)
        begin
          next_st.gen = pbl_pkg::GEN_IDLE;
          next_st.single_done = 1'b1;
          ev[pbl_pkg::IRQ_GEN_DONE] = 1'b1;
        end
        else if (st.gen_cnt == pbl_pkg::IPG_LEN - 16'h0001)
        begin
          next_st.gen = pbl_pkg::GEN_DATA;
          next_st.gen_cnt = 16'h0000;
          next_st.tx_sop = 1'b1;
        end
      end
      default:
      begin
        next_st.gen = pbl_pkg::GEN_IDLE;
      end
    endcase
    // constant pattern cycles through the byte by packet position
    next_st.tx_bit = st.pkt_type ? gen_prbs_bit
      : pbl_pkg::CONST_BYTE[next_st.gen_cnt[2:0]];
    // checker lock: a run of good bits locks, a run of bad bits loses it
    if (!chk_on)
    begin
      next_st.locked = 1'b0;
      next_st.run = 4'h0;
      next_st.fill = 5'h00;
    end
    else if (chk_step)
    begin
      if (!st.locked && st.fill != pbl_pkg::SEED_LEN)
      begin
        // stale register contents could fake a run of matches
        next_st.fill = st.fill + 5'h01;
      end
      else if (!st.locked)
      begin
        next_st.run = mismatch ? 4'h0 : st.run + 4'h1;
        if (st.run == pbl_pkg::LOCK_RUN - 4'h1 && !mismatch)
        begin
          next_st.locked = 1'b1;
          next_st.run = 4'h0;
        end
      end
      else
      begin
        next_st.run = mismatch ? st.run + 4'h1 : 4'h0;
        if (mismatch && st.run == pbl_pkg::LOSS_RUN - 4'h1)
        begin
          next_st.locked = 1'b0;
          next_st.sync_loss = 1'b1;
          next_st.fill = 5'h00;
          next_st.run = 4'h0;
          ev[pbl_pkg::IRQ_SYNC_LOSS] = 1'b1;
        end
        if (mismatch)
        begin
          if (st.err_cnt != pbl_pkg::ERR_MAX)
          begin
            next_st.err_cnt = st.err_cnt + 16'h0001;
          end
          else if (st.cnt_mode)
          begin
            next_st.err_cnt = 16'h0000;
            next_st.wrap = 1'b1;
            ev[pbl_pkg::IRQ_WRAP] = 1'b1;
          end
        end
      end
    end
    if (bus.rd && bus.addr == pbl_pkg::REG_ERR_COUNT)
    begin
      next_st.err_cnt = 16'h0000;
    end
    // events set after the clear so they are never lost
    next_st.irq_stat = next_st.irq_stat | ev;
    next_st.irq = |(next_st.irq_stat & st.irq_en);
    // loopback decode: only the exact pcs, analog and reverse codes enable a path; the xmii path is never enabled
    next_st.path = '{pcs: st.lb[3:0] == pbl_pkg::LB_PCS,
      analog: st.lb[3:0] == pbl_pkg::LB_ANALOG,
      reverse: st.lb[3:0] == pbl_pkg::LB_REVERSE,
      xmii: 1'b0, mdi_tx_en: 1'b1};
    // in xmii loopback the line output follows the mdi transmit bit
    if (st.lb[3:0] == pbl_pkg::LB_XMII)
    begin
      next_st.path.mdi_tx_en = st.lb[4];
    end
  end
  always_ff @(posedge CLK_I)
  begin
    if (RESET_I)
    begin
      st <= '{poly: pbl_pkg::POLY_RESET, gen: pbl_pkg::GEN_IDLE,
        path: '{pcs: 1'b0, analog: 1'b0, reverse: 1'b0, xmii: 1'b0, mdi_tx_en: 1'b1},
        default: '0};
    end
    else
    begin
      st <= next_st;
    end
  end
  assign RDATA_O = st.rdata;
  assign TX_VALID_O = st.tx_valid;
  assign TX_BIT_O = st.tx_bit;
  assign TX_SOP_O = st.tx_sop;
  assign LB_PCS_O = st.path.pcs;
  assign LB_ANALOG_O = st.path.analog;
  assign LB_REVERSE_O = st.path.reverse;
  assign LB_XMII_O = st.path.xmii;
  assign MDI_TX_EN_O = st.path.mdi_tx_en;
  assign ERR_WRAP_O = st.wrap;
  assign IRQ_O = st.irq;

  wrap_pulse_a: assert property (@(posedge CLK_I) disable iff (RESET_I)
    ERR_WRAP_O |-> st.cnt_mode && st.err_cnt == 16'h0000)
    else $error("wrap pulse without wrap to zero");
  single_sat_a: assert property (@(posedge CLK_I) disable iff (RESET_I)
    (!st.cnt_mode && st.err_cnt == 16'hffff && !(RD_I && ADDR_I == 5'h1b))
    |=> st.err_cnt == 16'hffff)
    else $error("single mode counter left maximum");
  gen_start_a: assert property (@(posedge CLK_I) disable iff (RESET_I)
    (st.gen == pbl_pkg::GEN_IDLE && st.gen_en && !st.single_done)
    |=> TX_SOP_O && st.gen == pbl_pkg::GEN_DATA)
    else $error("generator did not start");
  gen_stop_a: assert property (@(posedge CLK_I) disable iff (RESET_I)
    (!st.gen_en && st.gen != pbl_pkg::GEN_IDLE) |=> st.gen == pbl_pkg::GEN_IDLE)
    else $error("generator did not stop");
  single_pkt_a: assert property (@(posedge CLK_I) disable iff (RESET_I)
    (st.gen == pbl_pkg::GEN_GAP && !st.pkt_type && st.gen_en)
    |=> st.gen == pbl_pkg::GEN_IDLE ##1 !TX_SOP_O)
    else $error("constant mode sent more than one packet");
  no_lock_const_a: assert property (@(posedge CLK_I) disable iff (RESET_I)
    !st.pkt_type |=> !st.locked)
    else $error("checker locked in constant mode");
  loss_latch_a: assert property (@(posedge CLK_I) disable iff (RESET_I)
    (st.sync_loss && !(RD_I && ADDR_I == 5'h16)) |=> st.sync_loss)
    else $error("sync loss dropped without read");
  lb_reserved_a: assert property (@(posedge CLK_I) disable iff (RESET_I)
    (st.lb[3:0] != 4'h1 && st.lb[3:0] != 4'h2 && st.lb[3:0] != 4'h4)
    |=> !(LB_PCS_O || LB_ANALOG_O || LB_REVERSE_O))
    else $error("reserved loopback code opened a path");
  mdi_gate_a: assert property (@(posedge CLK_I) disable iff (RESET_I)
    (st.lb == 5'h08) |=> !MDI_TX_EN_O)
    else $error("line output not suppressed in xmii loopback");
  seed_first_a: assert property (@(posedge CLK_I) disable iff (RESET_I)
    (!st.locked && st.fill != pbl_pkg::SEED_LEN) |=> !st.locked)
    else $error("checker locked before its register was seeded");
endmodule

// ### sim/test_pbl_bist.sv
// self-checking bench for the self-test and loopback control block
`timescale 1ns/100ps
module test_pbl_bist;
  logic clk, rst, wr, rd, rx_valid, rx_bit, flip;
  logic [4:0] addr;
  logic [15:0] wdata, rdata, q, d;
  logic tx_valid, tx_bit, tx_sop, lb_pcs, lb_analog, lb_reverse, lb_xmii;
  logic mdi_tx_en, err_wrap, irq;
  logic [3:0] codes [7] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hf};
  logic cap [$];
  int bad_count, n_compared, cycles, n, rx_mode, rp;

  pbl_bist i_pbl_bist
  (
    .CLK_I(clk),
    .RESET_I(rst),
    .ADDR_I(addr),
    .WDATA_I(wdata),
    .WR_I(wr),
    .RD_I(rd),
    .RX_VALID_I(rx_valid),
    .RX_BIT_I(rx_bit),
    .RDATA_O(rdata),
    .TX_VALID_O(tx_valid),
    .TX_BIT_O(tx_bit),
    .TX_SOP_O(tx_sop),
    .LB_PCS_O(lb_pcs),
    .LB_ANALOG_O(lb_analog),
    .LB_REVERSE_O(lb_reverse),
    .LB_XMII_O(lb_xmii),
    .MDI_TX_EN_O(mdi_tx_en),
    .ERR_WRAP_O(err_wrap),
    .IRQ_O(irq)
  );

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task end_of_test;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ceiling well above the roughly 3700 cycles the tests need
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      bad_count++;
      end_of_test();
    end
  end

  // mode 1 loops the generator back, mode 2 replays captured bits
  always @(posedge clk)
    if (rx_mode == 1)
    begin
      rx_valid <= tx_valid;
      rx_bit <= tx_bit ^ flip;
      if (tx_valid === 1'b1 && cap.size() < 400)
        cap.push_back(tx_bit);
    end
    else if (rx_mode == 2 && rp < cap.size())
    begin
      rx_valid <= 1'b1;
      rx_bit <= cap[rp];
      rp <= rp + 1;
    end
    else
      rx_valid <= 1'b0;

  task check(string what, logic [15:0] seen, logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task wr_reg(logic [4:0] a, logic [15:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // data stand only in the cycle after the strobe
  task rd_reg(logic [4:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 q = rdata;
  endtask

  task settle;
    repeat (2) @(posedge clk);
    #1;
  endtask

  task wait_sop;
    n = 0;
    while (tx_sop !== 1'b1 && n < 100)
    begin
      @(posedge clk);
      #1 n++;
    end
    check("packet start", {15'h0, tx_sop}, 16'h0001);
  endtask

  initial
  begin
    rst = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 5'h00;
    wdata = 16'h0000;
    rx_valid = 1'b0;
    rx_bit = 1'b0;
    flip = 1'b0;
    rx_mode = 0;
    rp = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rd_reg(pbl_pkg::REG_CTRL);
    check("ctrl reset", q, 16'h0100);
    check("mdi reset", {15'h0, mdi_tx_en}, 16'h0001);
    rd_reg(pbl_pkg::REG_POLY);
    check("poly reset", q, pbl_pkg::POLY_RESET);
    rd_reg(5'h1f);
    check("unmapped read", q, 16'h0000);
    $display("test reset done");

    foreach (codes[i])
    begin
      d = {10'h0, 1'b0, codes[i], 2'h0};
      wr_reg(pbl_pkg::REG_CTRL, d);
      settle();
      check("paths", {12'h0, lb_pcs, lb_analog, lb_reverse, lb_xmii},
        {12'h0, codes[i] == 4'h1, codes[i] == 4'h2, codes[i] == 4'h4, 1'b0});
      check("mdi", {15'h0, mdi_tx_en}, {15'h0, codes[i] != 4'h8});
      rd_reg(pbl_pkg::REG_CTRL);
      check("ctrl loopback", q, d | 16'h0100);
    end
    wr_reg(pbl_pkg::REG_CTRL, 16'h0060);
    settle();
    check("mdi pass", {15'h0, mdi_tx_en}, 16'h0001);
    wr_reg(pbl_pkg::REG_CTRL, 16'h0000);
    $display("test loopback done");

    wr_reg(pbl_pkg::REG_CTRL, 16'h1000);
    wait_sop();
    n = 0;
    // window wide enough to catch a wrongly repeated packet
    repeat (1600)
    begin
      @(posedge clk);
      #1 if (tx_valid === 1'b1) n++;
    end
    check("constant length", n[15:0], pbl_pkg::PKT_LEN);
    rd_reg(pbl_pkg::REG_CTRL);
    check("gen off", q & 16'h0200, 16'h0000);
    rd_reg(pbl_pkg::REG_IRQ_STATUS);
    check("done status", q, 16'h0004);
    check("irq masked", {15'h0, irq}, 16'h0000);
    wr_reg(pbl_pkg::REG_IRQ_ENABLE, 16'h0004);
    settle();
    check("irq raised", {15'h0, irq}, 16'h0001);
    wr_reg(pbl_pkg::REG_IRQ_CLEAR, 16'h0004);
    settle();
    check("irq cleared", {15'h0, irq}, 16'h0000);
    rd_reg(pbl_pkg::REG_IRQ_CLEAR);
    check("clear reads 0", q, 16'h0000);
    $display("test constant packet done");

    rx_mode = 1;
    wr_reg(pbl_pkg::REG_IRQ_ENABLE, 16'h0001);
    wr_reg(pbl_pkg::REG_CTRL, 16'h3000);
    wait_sop();
    repeat (1525) @(posedge clk);
    wait_sop();
    repeat (20) @(posedge clk);
    rd_reg(pbl_pkg::REG_CTRL);
    check("lock and active", q & 16'h0e00, 16'h0a00);
    flip <= 1'b1;
    repeat (6) @(posedge clk);
    flip <= 1'b0;
    repeat (2) @(posedge clk);
    rd_reg(pbl_pkg::REG_CTRL);
    check("sync loss set", q & 16'h0400, 16'h0400);
    rd_reg(pbl_pkg::REG_CTRL);
    check("sync loss read", q & 16'h0400, 16'h0000);
    rd_reg(pbl_pkg::REG_ERR_COUNT);
    check("errors counted", q, {12'h000, pbl_pkg::LOSS_RUN});
    rd_reg(pbl_pkg::REG_IRQ_STATUS);
    check("loss status", q & 16'h0001, 16'h0001);
    check("loss irq", {15'h0, irq}, 16'h0001);
    wr_reg(pbl_pkg::REG_CTRL, 16'h2000);
    settle();
    check("gen stopped", {15'h0, tx_valid}, 16'h0000);
    rd_reg(pbl_pkg::REG_CTRL);
    check("status off", q & 16'h0200, 16'h0000);
    $display("test random loopback done");

    rx_mode = 2;
    repeat (420) @(posedge clk);
    rd_reg(pbl_pkg::REG_CTRL);
    check("check only lock", q & 16'h0a00, 16'h0800);
    check("no wrap", {15'h0, err_wrap}, 16'h0000);
    $display("test checker only done");
    end_of_test();
  end
endmodule
